// ### reset_and_startup_clock_sequencer.sv
// reset and start-up clock sequencer top level
// Functional notes
// - straps pick start-up core clock ratio
// - software may reprogram ratio after reset
// - core reset driven on reset output
// - wait 4096 input clocks for lock
// - core then fetches from reset vector
// - test reset clears test-port state
// - bus strobes three-stated only in reset
// - straps choose multiplier or direct clock
module reset_and_startup_clock_sequencer
    import startup_pkg::*;
#(
    parameter int                   LOCK_CYCLES = startup_pkg::LOCK_WAIT_CYCLES,
    parameter logic [VECTOR_W-1:0]  VECTOR      = startup_pkg::RESET_VECTOR
) (
    input  wire logic                              clk,
    input  wire logic                              reset,
    input  wire logic [startup_pkg::STRAP_W-1:0]   clock_ratio_straps,
    input  wire logic                              trst_n,
    input  wire logic                              pmc_write,
    input  wire logic [startup_pkg::MULT_W-1:0]    pmc_mult,
    input  wire logic [startup_pkg::DIV_W-1:0]     pmc_div,
    input  wire logic                              pmc_bypass,
    input  wire logic                              core_rd_n,
    input  wire logic                              core_wr_n,
    input  wire logic                              core_ale,
    output logic                                   core_reset_output,
    output logic                                   core_fetch_start,
    output logic [startup_pkg::VECTOR_W-1:0]       core_fetch_addr,
    output logic                                   core_running,
    output logic [startup_pkg::MULT_W-1:0]         pll_mult,
    output logic [startup_pkg::DIV_W-1:0]          pll_div,
    output logic                                   core_clk_from_pll,
    output logic                                   test_port_reset,
    output logic                                   rd_n_out,
    output logic                                   rd_n_oe,
    output logic                                   wr_n_out,
    output logic                                   wr_n_oe,
    output logic                                   ale_out,
    output logic                                   ale_oe
);
    import startup_pkg::*;

    // ------------------------------------------------------------
    // pin synchronisers
    // ------------------------------------------------------------
    logic [STRAP_W-1:0] straps_sync;
    logic               trst_n_sync;

    pin_sync #(.W(STRAP_W), .RESET_VAL(8'h00)) u_strap_sync (
        .clk     (clk),
        .reset   (reset),
        .pin_in  (clock_ratio_straps),
        .pin_out (straps_sync)
    );

    pin_sync #(.W(1), .RESET_VAL(8'h00)) u_trst_sync (
        .clk     (clk),
        .reset   (reset),
        .pin_in  (trst_n),
        .pin_out (trst_n_sync)
    );

    // ------------------------------------------------------------
    // lock wait and sequencing
    // ------------------------------------------------------------
    seq_state_t              state_ff;
    seq_state_t              nxt_state;
    logic [LOCK_CNT_W-1:0]   lock_cnt_ff;
    logic [LOCK_CNT_W-1:0]   nxt_lock_cnt;
    logic                    fetch_ff;
    logic                    core_rst_ff;
    logic                    strap_taken_ff;
    logic                    nxt_fetch;
    logic                    nxt_core_rst;

    wire in_wait     = (state_ff == ST_LOCK_WAIT);
    wire lock_done   = in_wait && (lock_cnt_ff == LOCK_CNT_W'(LOCK_CYCLES - 1));
    wire strap_take  = in_wait && !strap_taken_ff &&
                       (lock_cnt_ff == LOCK_CNT_W'(STRAP_SAMPLE_AT));

    always_comb begin
        nxt_state    = state_ff;
        nxt_lock_cnt = lock_cnt_ff;
        unique case (state_ff)
            ST_LOCK_WAIT: begin
                nxt_lock_cnt = lock_cnt_ff + LOCK_CNT_W'(1);
                if (lock_done) begin
                    nxt_state = ST_RUN;
                end
            end
            ST_RUN: begin
                nxt_state    = ST_RUN;
                nxt_lock_cnt = lock_cnt_ff;
            end
        endcase
    end

    assign nxt_fetch    = lock_done;
    assign nxt_core_rst = core_rst_ff && !lock_done;

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            state_ff    <= ST_LOCK_WAIT;
            lock_cnt_ff <= '0;
            fetch_ff    <= 1'b0;
            core_rst_ff <= 1'b1;
        end else begin
            state_ff    <= nxt_state;
            lock_cnt_ff <= nxt_lock_cnt;
            fetch_ff    <= nxt_fetch;
            core_rst_ff <= nxt_core_rst;
        end
    end

    // ------------------------------------------------------------
    // core start outputs
    // ------------------------------------------------------------
    assign core_reset_output = core_rst_ff;
    assign core_fetch_start  = fetch_ff;
    assign core_fetch_addr   = VECTOR;
    assign core_running      = (state_ff == ST_RUN);

    // ------------------------------------------------------------
    // clock ratio selection
    // ------------------------------------------------------------
    logic [MULT_W-1:0] mult_ff;
    logic [DIV_W-1:0]  div_ff;
    logic              from_pll_ff;
    logic [MULT_W-1:0] strap_mult;
    logic              strap_pll;
    logic [MULT_W-1:0] nxt_mult;
    logic [DIV_W-1:0]  nxt_div;
    logic              nxt_from_pll;
    logic              nxt_strap_taken;

    // ------------------------------------------------------------
    // strap decode
    // ------------------------------------------------------------
    wire strap_low  = (straps_sync == STRAP_RATIO_LOW);
    wire strap_high = (straps_sync == STRAP_RATIO_HIGH);
    wire strap_mid  = (straps_sync == STRAP_RATIO_MID);

    assign strap_mult = strap_low  ? MULT_LOW  :
                        strap_high ? MULT_HIGH :
                        strap_mid  ? MULT_MID  : MULT_BYPASS;
    assign strap_pll  = (straps_sync != STRAP_BYPASS);

    // ------------------------------------------------------------
    // clock ratio registers
    // ------------------------------------------------------------
    wire sw_write = pmc_write && (state_ff == ST_RUN);

    assign nxt_mult        = strap_take ? strap_mult :
                             sw_write   ? pmc_mult   : mult_ff;
    assign nxt_div         = strap_take ? DIV_RESET  :
                             sw_write   ? pmc_div    : div_ff;
    assign nxt_from_pll    = strap_take ? strap_pll  :
                             sw_write   ? !pmc_bypass : from_pll_ff;
    assign nxt_strap_taken = strap_taken_ff || strap_take;

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            mult_ff        <= MULT_RESET;
            div_ff         <= DIV_RESET;
            from_pll_ff    <= 1'b0;
            strap_taken_ff <= 1'b0;
        end else begin
            mult_ff        <= nxt_mult;
            div_ff         <= nxt_div;
            from_pll_ff    <= nxt_from_pll;
            strap_taken_ff <= nxt_strap_taken;
        end
    end

    assign pll_mult          = mult_ff;
    assign pll_div           = div_ff;
    assign core_clk_from_pll = from_pll_ff;

    // ------------------------------------------------------------
    // test port reset
    // ------------------------------------------------------------
    assign test_port_reset = !trst_n_sync;

    // ------------------------------------------------------------
    // external bus strobes
    // ------------------------------------------------------------
    localparam logic [2:0] STROBE_IDLE = 3'h3;

    logic [2:0] strb_in;
    logic [2:0] strb_ff;

    // bit 0 read, bit 1 write, bit 2 address latch
    assign strb_in = {core_ale, core_wr_n, core_rd_n};

    for (genvar i = 0; i < 3; i++) begin : g_strobe
        // idle level while the core is held in reset
        wire nxt_strb = core_rst_ff ? STROBE_IDLE[i] : strb_in[i];

        always_ff @(posedge clk or posedge reset) begin
            if (reset) begin
                strb_ff[i] <= STROBE_IDLE[i];
            end else begin
                strb_ff[i] <= nxt_strb;
            end
        end
    end

    assign rd_n_out = strb_ff[0];
    assign wr_n_out = strb_ff[1];
    assign ale_out  = strb_ff[2];

    // ------------------------------------------------------------
    // output enables
    // ------------------------------------------------------------
    assign rd_n_oe  = !reset;
    assign wr_n_oe  = !reset;
    assign ale_oe   = !reset;
endmodule // reset_and_startup_clock_sequencer

// ### startup_pkg.sv
// constants shared by the start-up sequencer
package startup_pkg;
    // ------------------------------------------------------------
    // clock and timing
    // ------------------------------------------------------------
    localparam int          CLK_HZ            = 40_000_000;
    localparam int          LOCK_WAIT_CYCLES  = 4096;
    localparam int          STRAP_SAMPLE_AT   = 4;
    localparam int          LOCK_CNT_W        = 13;

    // ------------------------------------------------------------
    // clock ratio fields and straps
    // ------------------------------------------------------------
    localparam int          MULT_W            = 7;
    localparam int          DIV_W             = 2;
    localparam int          STRAP_W           = 2;
    localparam logic [1:0]  STRAP_RATIO_LOW   = 2'h0;
    localparam logic [1:0]  STRAP_RATIO_HIGH  = 2'h1;
    localparam logic [1:0]  STRAP_RATIO_MID   = 2'h2;
    localparam logic [1:0]  STRAP_BYPASS      = 2'h3;
    localparam logic [6:0]  MULT_LOW          = 7'h04;
    localparam logic [6:0]  MULT_HIGH         = 7'h10;
    localparam logic [6:0]  MULT_MID          = 7'h08;
    localparam logic [6:0]  MULT_BYPASS       = 7'h01;
    localparam logic [1:0]  DIV_RESET         = 2'h0;
    localparam logic [6:0]  MULT_RESET        = 7'h01;

    // ------------------------------------------------------------
    // reset vector
    // ------------------------------------------------------------
    localparam int          VECTOR_W          = 24;
    localparam logic [23:0] RESET_VECTOR      = 24'h001000;

    // ------------------------------------------------------------
    // sequencer states
    // ------------------------------------------------------------
    typedef enum logic [0:0] {
        ST_LOCK_WAIT = 1'b0,
        ST_RUN       = 1'b1
    } seq_state_t;
endpackage

// ### pin_sync.sv
// three-flop synchroniser with agreement filter for pin inputs
module pin_sync #(
    parameter int         W         = 1,
    parameter logic [7:0] RESET_VAL = 8'h00
) (
    input  wire logic         clk,
    input  wire logic         reset,
    input  wire logic [W-1:0] pin_in,
    output logic      [W-1:0] pin_out
);
    logic [W-1:0] s1_ff;
    logic [W-1:0] s2_ff;
    logic [W-1:0] s3_ff;
    logic [W-1:0] out_ff;
    logic [W-1:0] nxt_out;
    wire  [W-1:0] agree = ~(s2_ff ^ s3_ff);

    assign nxt_out = (agree & s2_ff) | (~agree & out_ff);
    assign pin_out = out_ff;

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            s1_ff  <= RESET_VAL[W-1:0];
            s2_ff  <= RESET_VAL[W-1:0];
            s3_ff  <= RESET_VAL[W-1:0];
            out_ff <= RESET_VAL[W-1:0];
        end else begin
            s1_ff  <= pin_in;
            s2_ff  <= s1_ff;
            s3_ff  <= s2_ff;
            out_ff <= nxt_out;
        end
    end
endmodule // pin_sync

// ### startup_properties.sv
// concurrent checks on the start-up sequencer ports
module startup_props
    import startup_pkg::*;
#(
    parameter int                  LOCK_CYCLES = 4096,
    parameter logic [VECTOR_W-1:0] VECTOR      = RESET_VECTOR
) (
    input wire logic                clk,
    input wire logic                reset,
    input wire logic                core_rd_n,
    input wire logic                pmc_write,
    input wire logic [MULT_W-1:0]   pmc_mult,
    input wire logic                pmc_bypass,
    input wire logic                core_reset_output,
    input wire logic                core_fetch_start,
    input wire logic [VECTOR_W-1:0] core_fetch_addr,
    input wire logic                core_running,
    input wire logic [MULT_W-1:0]   pll_mult,
    input wire logic                core_clk_from_pll,
    input wire logic                rd_n_out,
    input wire logic                rd_n_oe
);
    timeunit 1ns;
    timeprecision 100ps;
    int lock_cnt_ff;
    default clocking @(posedge clk); endclocking
    default disable iff (reset);
    always_ff @(posedge clk or posedge reset) begin
        if (reset)
            lock_cnt_ff <= 0;
        else if (core_reset_output)
            lock_cnt_ff <= lock_cnt_ff + 1;
    end
    AST_OE: assert property (rd_n_oe) else $error("read strobe not driven");
    AST_LOCK: assert property (core_fetch_start |-> lock_cnt_ff == LOCK_CYCLES)
        else $error("lock wait length wrong");
    AST_VEC: assert property (core_fetch_start |-> core_fetch_addr == VECTOR && core_running)
        else $error("fetch not at vector");
    AST_REL: assert property ($fell(core_reset_output) |-> core_fetch_start)
        else $error("reset output released early");
    AST_HOLD: assert property (core_running |=> core_running && !core_reset_output)
        else $error("run state lost");
    AST_PULSE: assert property (core_fetch_start |=> !core_fetch_start [*3]) else $error("fetch pulse long");
    AST_PMC: assert property (pmc_write && core_running |=>
        pll_mult == $past(pmc_mult) && core_clk_from_pll == !$past(pmc_bypass)) else $error("ratio write lost");
    AST_STRB: assert property (core_running && $past(core_running) |-> rd_n_out == $past(core_rd_n))
        else $error("read strobe not passed");
    AST_RSTO: assert property (core_reset_output |-> !core_running) else $error("run during reset");
endmodule // startup_props

bind reset_and_startup_clock_sequencer startup_props #(.LOCK_CYCLES(LOCK_CYCLES), .VECTOR(VECTOR)) i_startup_props (
    .clk, .reset, .core_rd_n, .pmc_write, .pmc_mult, .pmc_bypass, .core_reset_output, .core_fetch_start,
    .core_fetch_addr, .core_running, .pll_mult, .core_clk_from_pll, .rd_n_out, .rd_n_oe);

// ### board_model.sv
// board side: reset source and test-port pins
module board_model (
    input  wire logic rst_req,
    input  wire logic trst_req,
    output logic      reset,
    output logic      trst_n,
    output logic      tck
);
    timeunit 1ns;
    timeprecision 100ps;
    assign reset  = rst_req;
    assign trst_n = !(rst_req || trst_req);
    assign tck    = 1'b0;
endmodule // board_model

// ### reset_and_startup_clock_sequencer_tb.sv
// self-checking bench for the start-up sequencer
module reset_and_startup_clock_sequencer_tb import startup_pkg::*; ;
    timeunit 1ns;
    timeprecision 100ps;
    localparam int L = 16;
    logic clk = 0, rst_req = 1, trst_req = 0, reset, trst_n, tck, pw = 0, bp = 0, rd = 1, wr = 1, al = 0;
    logic [1:0] st = 0, dv = 0, pll_div;
    logic [6:0] mu = 0, pll_mult;
    logic [23:0] addr;
    logic rso, fs, run, cpll, tpr, rdo, rde, wro, wre, alo, ale;
    int err_total, check_count;
    always #12.5 clk = ~clk;
    board_model i_board_model (.rst_req, .trst_req, .reset, .trst_n, .tck);
    reset_and_startup_clock_sequencer #(.LOCK_CYCLES(L)) i_reset_and_startup_clock_sequencer (.clk, .reset,
        .clock_ratio_straps(st), .trst_n, .pmc_write(pw), .pmc_mult(mu), .pmc_div(dv), .pmc_bypass(bp),
        .core_rd_n(rd), .core_wr_n(wr), .core_ale(al), .core_reset_output(rso), .core_fetch_start(fs),
        .core_fetch_addr(addr), .core_running(run), .pll_mult, .pll_div, .core_clk_from_pll(cpll),
        .test_port_reset(tpr), .rd_n_out(rdo), .rd_n_oe(rde), .wr_n_out(wro), .wr_n_oe(wre),
        .ale_out(alo), .ale_oe(ale));
    task chk(string name, logic [31:0] exp, logic [31:0] got);
        check_count++;
        if (got !== exp) begin
            err_total++;
            $display("mismatch %s expected %0h seen %0h", name, exp, got);
        end
    endtask
    task give_verdict;
        $display("mismatches %0d checks %0d", err_total, check_count);
        if (err_total == 0 && check_count > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    task step;
        @(posedge clk);
        #2;
    endtask
    task scen_boot(logic [1:0] s, logic [6:0] m, logic p);
        int n;
        rst_req = 1;
        st = s;
        mu = 7'h55;
        repeat (10) step();
        chk("reset_pins", 9'h10C, {rso, run, rde, wre, ale, rdo, wro, alo, fs});
        rst_req = 0;
        n = 0;
        #1 chk("oe_release", 3'h7, {rde, wre, ale});
        do begin
            step();
            n++;
            pw = (n == 8);
            chk("reset_out", n < L, rso);
        end while (fs !== 1'b1 && n < 2 * L);
        chk("lock_len", L, n);
        chk("vector", RESET_VECTOR, addr);
        chk("ratio", {m, p, DIV_RESET}, {pll_mult, cpll, pll_div});
        step();
        chk("pulse", 2'h1, {fs, run});
    endtask
    task scen_pmc;
        pw = 1;
        {mu, bp, dv} = {7'h7F, 1'b0, 2'h3};
        step();
        chk("pmc_a", {7'h7F, 1'b1, 2'h3}, {pll_mult, cpll, pll_div});
        {mu, bp, dv} = {7'h05, 1'b1, 2'h1};
        step();
        pw = 0;
        step();
        chk("pmc_b", {7'h05, 1'b0, 2'h1}, {pll_mult, cpll, pll_div});
    endtask
    task scen_strobe;
        {rd, wr, al} = 3'h3;
        step();
        chk("strobe_a", 6'h1F, {rdo, wro, alo, rde, wre, ale});
        {rd, wr, al} = 3'h4;
        step();
        chk("strobe_b", 6'h27, {rdo, wro, alo, rde, wre, ale});
    endtask
    task scen_trst;
        trst_req = 1;
        repeat (5) step();
        chk("test_reset_on", 1'b1, tpr);
        trst_req = 0;
        repeat (5) step();
        chk("test_reset_off", 1'b0, tpr);
        chk("test_clock_low", 1'b0, tck);
    endtask
    initial begin
        scen_boot(STRAP_RATIO_LOW, MULT_LOW, 1'b1);
        scen_boot(STRAP_RATIO_HIGH, MULT_HIGH, 1'b1);
        scen_boot(STRAP_RATIO_MID, MULT_MID, 1'b1);
        scen_boot(STRAP_BYPASS, MULT_BYPASS, 1'b0);
        scen_pmc();
        scen_strobe();
        scen_trst();
        give_verdict();
    end
    initial begin
        #100000;
        err_total++;
        give_verdict();
    end
endmodule // reset_and_startup_clock_sequencer_tb
